/* rtl/flash_block_protection.sv */
// Protection checker between the core's fetch and table paths and the flash array.
// Assumes array read data is valid in the cycle of the request and that the guard
// bytes are reached over a classic Wishbone slave with 32-bit data.
`timescale 1ns/100ps
`default_nettype none
module flash_block_protection (
  // Clock and reset.
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Wishbone slave.
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [31:0]                  adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [31:0]                  dat_i,
  output logic [31:0]                       dat_o,
  output logic                              ack_o,
  // Device mode.
  input  wire logic                         prog_mode_i,
  // Core access request and array data.
  input  wire flash_guard_pkg::access_req_t req_i,
  input  wire logic [7:0]                   arr_rdata_i,
  // Access answer.
  output flash_guard_pkg::access_resp_t     resp_o
);

  // Guard byte values.
  logic [7:0] code_low;
  logic [7:0] code_high;
  logic [7:0] write_low;
  logic [7:0] write_high;
  logic [7:0] table_low;
  logic [7:0] table_high;
  logic [7:0] boot_cfg;
  logic [1:0] boot_size_select;

  // Bus decode.
  logic [29:0] word_idx;
  logic        bus_req;
  logic        bus_wr;
  logic        cfg_wr_ok;
  logic        hit_boot;
  logic        hit_code_low;
  logic        hit_code_high;
  logic        hit_write_low;
  logic        hit_write_high;
  logic        hit_table_low;
  logic        hit_table_high;
  logic [7:0]  rd_byte;

  // Access decision.
  logic [3:0]  tgt_region;
  logic [3:0]  exec_region;
  logic        tgt_is_blk;
  logic [2:0]  blk;
  logic        same_block;
  logic        read_ok;
  logic        write_ok;
  logic        xblock_ok;
  logic        allow;
  logic        is_write;

  // Registered outputs.
  logic                           ack_q;
  logic [31:0]                    dat_q;
  flash_guard_pkg::access_resp_t  resp_q;
  flash_guard_pkg::access_resp_t  resp_d;

  // Classic cycle: one strobe gives one ack a cycle later; sel lane 0 carries the byte.
  assign word_idx       = adr_i[31:2];
  assign bus_req        = cyc_i & stb_i & ~ack_q;
  assign bus_wr         = bus_req & we_i & sel_i[0];
  assign cfg_wr_ok      = write_high[flash_guard_pkg::BIT_CONFIG] | prog_mode_i;
  assign hit_boot       = (word_idx == flash_guard_pkg::IDX_BOOT_CFG);
  assign hit_code_low   = (word_idx == flash_guard_pkg::IDX_CODE_LOW);
  assign hit_code_high  = (word_idx == flash_guard_pkg::IDX_CODE_HIGH);
  assign hit_write_low  = (word_idx == flash_guard_pkg::IDX_WRITE_LOW);
  assign hit_write_high = (word_idx == flash_guard_pkg::IDX_WRITE_HIGH);
  assign hit_table_low  = (word_idx == flash_guard_pkg::IDX_TABLE_LOW);
  assign hit_table_high = (word_idx == flash_guard_pkg::IDX_TABLE_HIGH);

  // Unmapped words read as zero and swallow writes.
  assign rd_byte = hit_boot       ? boot_cfg   :
                   hit_code_low   ? code_low   :
                   hit_code_high  ? code_high  :
                   hit_write_low  ? write_low  :
                   hit_write_high ? write_high :
                   hit_table_low  ? table_low  :
                   hit_table_high ? table_high : 8'h00;

  assign boot_size_select = boot_cfg[flash_guard_pkg::BOOT_SIZE_LSB+1:flash_guard_pkg::BOOT_SIZE_LSB];

  guard_byte #(
    .IMPL_MASK  (flash_guard_pkg::MASK_BOOT_CFG),
    .CLEAR_MASK (flash_guard_pkg::MASK_NONE),
    .RESET_VAL  (flash_guard_pkg::RESET_BOOT_CFG)
  ) u_boot_cfg (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (bus_wr & hit_boot & cfg_wr_ok),
    .prog_i  (prog_mode_i),
    .wdata_i (dat_i[7:0]),
    .q_o     (boot_cfg)
  );

  guard_byte #(
    .IMPL_MASK  (flash_guard_pkg::MASK_FULL),
    .CLEAR_MASK (flash_guard_pkg::MASK_FULL),
    .RESET_VAL  (flash_guard_pkg::MASK_FULL)
  ) u_code_low (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (bus_wr & hit_code_low & cfg_wr_ok),
    .prog_i  (prog_mode_i),
    .wdata_i (dat_i[7:0]),
    .q_o     (code_low)
  );

  guard_byte #(
    .IMPL_MASK  (flash_guard_pkg::MASK_CODE_HIGH),
    .CLEAR_MASK (flash_guard_pkg::MASK_CODE_HIGH),
    .RESET_VAL  (flash_guard_pkg::MASK_FULL)
  ) u_code_high (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (bus_wr & hit_code_high & cfg_wr_ok),
    .prog_i  (prog_mode_i),
    .wdata_i (dat_i[7:0]),
    .q_o     (code_high)
  );

  guard_byte #(
    .IMPL_MASK  (flash_guard_pkg::MASK_FULL),
    .CLEAR_MASK (flash_guard_pkg::MASK_FULL),
    .RESET_VAL  (flash_guard_pkg::MASK_FULL)
  ) u_write_low (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (bus_wr & hit_write_low & cfg_wr_ok),
    .prog_i  (prog_mode_i),
    .wdata_i (dat_i[7:0]),
    .q_o     (write_low)
  );

  // The config lock bit is left out of the clear mask, so only programming mode moves it.
  guard_byte #(
    .IMPL_MASK  (flash_guard_pkg::MASK_WRITE_HIGH),
    .CLEAR_MASK (flash_guard_pkg::CLR_WRITE_HIGH),
    .RESET_VAL  (flash_guard_pkg::MASK_FULL)
  ) u_write_high (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (bus_wr & hit_write_high & cfg_wr_ok),
    .prog_i  (prog_mode_i),
    .wdata_i (dat_i[7:0]),
    .q_o     (write_high)
  );

  guard_byte #(
    .IMPL_MASK  (flash_guard_pkg::MASK_FULL),
    .CLEAR_MASK (flash_guard_pkg::MASK_FULL),
    .RESET_VAL  (flash_guard_pkg::MASK_FULL)
  ) u_table_low (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (bus_wr & hit_table_low & cfg_wr_ok),
    .prog_i  (prog_mode_i),
    .wdata_i (dat_i[7:0]),
    .q_o     (table_low)
  );

  guard_byte #(
    .IMPL_MASK  (flash_guard_pkg::MASK_TABLE_HIGH),
    .CLEAR_MASK (flash_guard_pkg::MASK_TABLE_HIGH),
    .RESET_VAL  (flash_guard_pkg::MASK_FULL)
  ) u_table_high (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (bus_wr & hit_table_high & cfg_wr_ok),
    .prog_i  (prog_mode_i),
    .wdata_i (dat_i[7:0]),
    .q_o     (table_high)
  );

  // Region of the target and of the instruction that issued the access.
  region_decode u_tgt_region (
    .addr_i      (req_i.target),
    .boot_size_i (boot_size_select),
    .region_o    (tgt_region)
  );

  region_decode u_exec_region (
    .addr_i      (req_i.pc),
    .boot_size_i (boot_size_select),
    .region_o    (exec_region)
  );

  // Per-region guard bits; a cleared bit means locked.
  assign tgt_is_blk = (tgt_region < flash_guard_pkg::REG_BOOT);
  assign blk        = tgt_region[2:0];
  assign same_block = (exec_region == tgt_region);
  assign read_ok    = req_i.eeprom ? code_high[flash_guard_pkg::BIT_EEPROM] :
                      tgt_is_blk ? code_low[blk] :
                      (tgt_region == flash_guard_pkg::REG_BOOT) ?
                        code_high[flash_guard_pkg::BIT_BOOT] : 1'b1;
  assign write_ok   = req_i.eeprom ? write_high[flash_guard_pkg::BIT_EEPROM] :
                      tgt_is_blk ? write_low[blk] :
                      (tgt_region == flash_guard_pkg::REG_BOOT) ?
                        write_high[flash_guard_pkg::BIT_BOOT] :
                      (tgt_region == flash_guard_pkg::REG_CONFIG) ?
                        write_high[flash_guard_pkg::BIT_CONFIG] : 1'b1;
  assign xblock_ok  = same_block | req_i.eeprom |
                      (tgt_is_blk ? table_low[blk] :
                       (tgt_region == flash_guard_pkg::REG_BOOT) ?
                         table_high[flash_guard_pkg::BIT_BOOT] : 1'b1);
  assign is_write   = (req_i.kind == flash_guard_pkg::ACC_TBLWR) |
                      (req_i.kind == flash_guard_pkg::ACC_ERASE);

  // Fetches are never refused; unknown kinds are refused to fail safe.
  always_comb begin
    case (req_i.kind)
      flash_guard_pkg::ACC_FETCH: allow = 1'b1;
      flash_guard_pkg::ACC_TBLRD: allow = xblock_ok;
      flash_guard_pkg::ACC_TBLWR: allow = write_ok;
      flash_guard_pkg::ACC_ERASE: allow = write_ok;
      flash_guard_pkg::ACC_EXTRD: allow = read_ok;
      default:                    allow = 1'b0;
    endcase
  end

  // A refused read returns zero and a refused write never commits; the core never waits.
  assign resp_d.valid  = req_i.valid;
  assign resp_d.allow  = req_i.valid & allow;
  assign resp_d.commit = req_i.valid & allow & is_write;
  assign resp_d.rdata  = (req_i.valid & allow & ~is_write) ? arr_rdata_i : 8'h00;

  // Bus answer and access answer are both registered one cycle after the request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      dat_q  <= 32'h00000000;
      resp_q <= '0;
    end else begin
      ack_q  <= bus_req;
      dat_q  <= {24'h000000, rd_byte};
      resp_q <= resp_d;
    end
  end

  assign ack_o  = ack_q;
  assign dat_o  = dat_q;
  assign resp_o = resp_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus handshake: a strobe taken with ack low gives exactly one ack pulse.
  sequence bus_strobe_s;
    cyc_i & stb_i & ~ack_q;
  endsequence

  sequence ack_pulse_s;
    ack_q ##1 ~ack_q;
  endsequence

  bus_ack_pulse_a: assert property (bus_strobe_s |=> ack_pulse_s)
    else $error("Bus ack not a single cycle after strobe.");

  // Answers that do not depend on the guard bytes.
  fetch_allowed_a: assert property (req_i.valid
    & (req_i.kind == flash_guard_pkg::ACC_FETCH) |=> resp_q.valid & resp_q.allow)
    else $error("Fetch was refused.");
  blocked_zero_a: assert property (resp_q.valid & ~resp_q.allow
    |-> (resp_q.rdata == 8'h00) & ~resp_q.commit)
    else $error("Refused access leaked data or committed.");
  read_no_commit_a: assert property (req_i.valid & ~is_write |=> ~resp_q.commit)
    else $error("Read access raised the array write enable.");

  // Program block locks; a cleared guard bit means locked.
  block_read_a: assert property (req_i.valid & ~req_i.eeprom & tgt_is_blk
    & (req_i.kind == flash_guard_pkg::ACC_EXTRD) |=> resp_q.allow == $past(code_low[blk]))
    else $error("Block read-out lock not obeyed.");
  block_write_a: assert property (req_i.valid & is_write & ~req_i.eeprom & tgt_is_blk
    & ~write_low[blk] |=> ~resp_q.commit)
    else $error("Write to locked block committed.");
  xblock_read_a: assert property (req_i.valid & ~req_i.eeprom & tgt_is_blk
    & (req_i.kind == flash_guard_pkg::ACC_TBLRD) & ~table_low[blk]
    & (exec_region != tgt_region) |=> ~resp_q.allow)
    else $error("Cross-block table read passed a lock.");
  own_block_read_a: assert property (req_i.valid
    & (req_i.kind == flash_guard_pkg::ACC_TBLRD) & (exec_region == tgt_region) |=> resp_q.allow)
    else $error("Table read within own block refused.");

  // Address map: program block 1 and the last program block, block 7.
  block1_map_a: assert property ((req_i.target >= flash_guard_pkg::BLOCK1_START)
    & (req_i.target < (flash_guard_pkg::BLOCK1_START << 1)) |-> tgt_region == 4'h1)
    else $error("Block 1 range misplaced.");
  block7_map_a: assert property ((req_i.target < flash_guard_pkg::PROG_END)
    & (req_i.target >= flash_guard_pkg::PROG_END - flash_guard_pkg::BLOCK1_START)
    |-> tgt_region == 4'h7)
    else $error("Block 7 range misplaced.");

  // Data EEPROM and boot block locks.
  eeprom_read_a: assert property (req_i.valid & req_i.eeprom
    & (req_i.kind == flash_guard_pkg::ACC_EXTRD)
    |=> resp_q.allow == $past(code_high[flash_guard_pkg::BIT_EEPROM]))
    else $error("EEPROM read-out lock not obeyed.");
  boot_read_a: assert property (req_i.valid & ~req_i.eeprom
    & (req_i.kind == flash_guard_pkg::ACC_EXTRD) & (req_i.target < flash_guard_pkg::BOOT_END_1K)
    |=> resp_q.allow == $past(code_high[flash_guard_pkg::BIT_BOOT]))
    else $error("Boot read-out lock not obeyed.");
  eeprom_write_a: assert property (req_i.valid & is_write & req_i.eeprom
    |=> resp_q.commit == $past(write_high[flash_guard_pkg::BIT_EEPROM]))
    else $error("EEPROM write lock not obeyed.");
  boot_write_a: assert property (req_i.valid & is_write & ~req_i.eeprom
    & (tgt_region == flash_guard_pkg::REG_BOOT)
    |=> resp_q.commit == $past(write_high[flash_guard_pkg::BIT_BOOT]))
    else $error("Boot write lock not obeyed.");
  boot_xblock_a: assert property (req_i.valid & ~req_i.eeprom
    & (req_i.kind == flash_guard_pkg::ACC_TBLRD) & (tgt_region == flash_guard_pkg::REG_BOOT)
    & (exec_region != flash_guard_pkg::REG_BOOT)
    |=> resp_q.allow == $past(table_high[flash_guard_pkg::BIT_BOOT]))
    else $error("Boot table-read lock not obeyed.");

  // Configuration range and its lock; unimplemented high-byte bits.
  config_write_a: assert property (req_i.valid & is_write & ~req_i.eeprom
    & (tgt_region == flash_guard_pkg::REG_CONFIG) & ~write_high[flash_guard_pkg::BIT_CONFIG]
    |=> ~resp_q.commit)
    else $error("Config write passed its lock.");
  config_lock_a: assert property ($changed(write_high[flash_guard_pkg::BIT_CONFIG])
    |-> $past(prog_mode_i))
    else $error("Config lock moved outside programming mode.");
  unimpl_zero_a: assert property ((code_high[5:0] == 6'h00) & (write_high[4:0] == 5'h00)
    & (table_high[5:0] == 6'h00))
    else $error("Unimplemented guard bits not zero.");

  // Boot block end for each size select.
  boot_region_a: assert property ((boot_size_select == flash_guard_pkg::BOOT_1K)
    & (req_i.target >= flash_guard_pkg::BOOT_END_1K)
    & (req_i.target < flash_guard_pkg::BLOCK1_START) |-> tgt_region == 4'h0)
    else $error("1K boot block end misplaced.");
  boot_2k_end_a: assert property ((boot_size_select == flash_guard_pkg::BOOT_2K)
    & (req_i.target >= flash_guard_pkg::BOOT_END_1K)
    & (req_i.target < flash_guard_pkg::BOOT_END_2K) |-> tgt_region == flash_guard_pkg::REG_BOOT)
    else $error("2K boot block end misplaced.");
  boot_4k_end_a: assert property (boot_size_select[1]
    & (req_i.target >= flash_guard_pkg::BOOT_END_2K)
    & (req_i.target < flash_guard_pkg::BOOT_END_4K) |-> tgt_region == flash_guard_pkg::REG_BOOT)
    else $error("4K boot block end misplaced.");

endmodule
`default_nettype wire

/* rtl/flash_guard_pkg.sv */
// Constants, register indices and carrier types of the flash protection checker.
// Assumes one core clock; the guard bytes live behind a classic Wishbone slave.
// Notes on behaviour
// - Blocks 1-3 start 004000h, 008000h, 00C000h, 16 KB.
// - Blocks 4-7 start 010000h onward, end 01FFFFh.
// - Block 0 spans boot end to 003FFFh.
// - Code-guard bit n zero locks block n read-out.
// - Write-guard bit n zero refuses block n writes.
// - Table-read bit zero blocks reads from other blocks.
// - High code-guard bit 7 zero locks EEPROM read.
// - High code-guard bit 6 zero locks boot read.
// - High write-guard bit 7 zero locks EEPROM writes.
// - High write-guard bit 6 zero locks boot writes.
// - High write-guard bit 5 zero locks config range.
// - Config lock bit changes only in programming mode.
// - Unimplemented high-byte bits always read zero.
// - Boot size: 00 1K, 01 2K, else 4K words.
// - Boot table-read bit zero blocks foreign reads.
package flash_guard_pkg;

  localparam int ADDR_W = 22;

  // Register indices; the Wishbone byte address is four times each.
  localparam logic [29:0] IDX_BOOT_CFG    = 30'h00300006;
  localparam logic [29:0] IDX_CODE_LOW    = 30'h00300008;
  localparam logic [29:0] IDX_CODE_HIGH   = 30'h00300009;
  localparam logic [29:0] IDX_WRITE_LOW   = 30'h0030000a;
  localparam logic [29:0] IDX_WRITE_HIGH  = 30'h0030000b;
  localparam logic [29:0] IDX_TABLE_LOW   = 30'h0030000c;
  localparam logic [29:0] IDX_TABLE_HIGH  = 30'h0030000d;

  // Implemented bits, bits clearable in normal execution, and reset values.
  localparam logic [7:0] MASK_FULL        = 8'hff;
  localparam logic [7:0] MASK_CODE_HIGH   = 8'hc0;
  localparam logic [7:0] MASK_WRITE_HIGH  = 8'he0;
  localparam logic [7:0] CLR_WRITE_HIGH   = 8'hc0;
  localparam logic [7:0] MASK_TABLE_HIGH  = 8'h40;
  localparam logic [7:0] MASK_BOOT_CFG    = 8'h30;
  localparam logic [7:0] MASK_NONE        = 8'h00;
  localparam logic [7:0] RESET_BOOT_CFG   = 8'h00;

  // Field positions inside the high bytes and the boot configuration byte.
  localparam int BIT_EEPROM      = 7;
  localparam int BIT_BOOT        = 6;
  localparam int BIT_CONFIG      = 5;
  localparam int BOOT_SIZE_LSB   = 4;

  // Memory map of the program array and the configuration space.
  localparam logic [ADDR_W-1:0] BOOT_END_1K   = 22'h000800;
  localparam logic [ADDR_W-1:0] BOOT_END_2K   = 22'h001000;
  localparam logic [ADDR_W-1:0] BOOT_END_4K   = 22'h002000;
  localparam logic [ADDR_W-1:0] BLOCK1_START  = 22'h004000;
  localparam logic [ADDR_W-1:0] PROG_END      = 22'h020000;
  localparam logic [13:0]       CONFIG_PAGE   = 14'h3000;
  localparam int                BLOCK_LSB     = 14;
  localparam int                PAGE_LSB      = 8;

  typedef enum logic [1:0] {
    BOOT_1K  = 2'b00,
    BOOT_2K  = 2'b01,
    BOOT_4K  = 2'b10,
    BOOT_4KB = 2'b11
  } boot_size_t;

  // Region codes: 0-7 are program blocks.
  localparam logic [3:0] REG_BOOT   = 4'h8;
  localparam logic [3:0] REG_CONFIG = 4'h9;
  localparam logic [3:0] REG_NONE   = 4'ha;

  typedef enum logic [2:0] {
    ACC_FETCH = 3'b000,
    ACC_TBLRD = 3'b001,
    ACC_TBLWR = 3'b010,
    ACC_ERASE = 3'b011,
    ACC_EXTRD = 3'b100
  } access_kind_t;

  typedef struct packed {
    logic              valid;
    access_kind_t      kind;
    logic              eeprom;
    logic [ADDR_W-1:0] target;
    logic [ADDR_W-1:0] pc;
  } access_req_t;

  typedef struct packed {
    logic       valid;
    logic       allow;
    logic       commit;
    logic [7:0] rdata;
  } access_resp_t;

endpackage

/* rtl/guard_byte.sv */
// One nonvolatile guard byte held as a register.
// Assumes writes arrive already qualified by the bus decoder.
`timescale 1ns/100ps
`default_nettype none
module guard_byte #(
  parameter logic [7:0] IMPL_MASK  = 8'hff,
  parameter logic [7:0] CLEAR_MASK = 8'hff,
  parameter logic [7:0] RESET_VAL  = 8'hff
) (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Write port.
  input  wire logic       wr_i,
  input  wire logic       prog_i,
  input  wire logic [7:0] wdata_i,
  // Stored value.
  output logic [7:0]      q_o
);

  logic [7:0] q_q;
  logic [7:0] q_d;

  // Normal execution may only clear the clearable bits; programming mode may set them.
  assign q_d = prog_i ? (wdata_i & IMPL_MASK) : (q_q & (wdata_i | ~CLEAR_MASK));
  assign q_o = q_q & IMPL_MASK;

  // The reset value stands in for the erased state of the cells.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_q <= RESET_VAL & IMPL_MASK;
    end else if (wr_i) begin
      q_q <= q_d;
    end
  end

endmodule
`default_nettype wire

/* rtl/region_decode.sv */
// Address to region decoder for the program array and configuration space.
// Assumes the boot size select comes from a register.
`timescale 1ns/100ps
`default_nettype none
module region_decode #(
  parameter int ADDR_W = flash_guard_pkg::ADDR_W
) (
  // Address and boot size.
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [1:0]        boot_size_i,
  // Region code.
  output logic [3:0]             region_o
);

  logic [ADDR_W-1:0] boot_end;
  logic              in_config;

  // Boot block end follows the size select; both upper codes mean 4K words.
  assign boot_end = (boot_size_i == flash_guard_pkg::BOOT_1K) ? flash_guard_pkg::BOOT_END_1K :
                    (boot_size_i == flash_guard_pkg::BOOT_2K) ? flash_guard_pkg::BOOT_END_2K :
                    flash_guard_pkg::BOOT_END_4K;
  assign in_config = (addr_i[ADDR_W-1:flash_guard_pkg::PAGE_LSB] ==
                      flash_guard_pkg::CONFIG_PAGE);

  // Blocks 1-7 are 16 KB slices picked by the three bits above the span.
  assign region_o = (addr_i < boot_end) ? flash_guard_pkg::REG_BOOT :
                    (addr_i < flash_guard_pkg::BLOCK1_START) ? 4'h0 :
                    (addr_i < flash_guard_pkg::PROG_END) ?
                      {1'b0, addr_i[flash_guard_pkg::BLOCK_LSB+2:flash_guard_pkg::BLOCK_LSB]} :
                    in_config ? flash_guard_pkg::REG_CONFIG : flash_guard_pkg::REG_NONE;

endmodule
`default_nettype wire

/* tb/core_port_model.sv */
// Behavioural core side of the access port: one request and the array byte.
// Assumes the bench changes its fields by non-blocking assignment after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module core_port_model (
  // Request fields from the bench.
  input  wire logic                   issue_i,
  input  wire logic [2:0]             kind_i,
  input  wire logic                   eeprom_i,
  input  wire logic [21:0]            target_i,
  input  wire logic [21:0]            pc_i,
  // Request and array data towards the checker.
  output flash_guard_pkg::access_req_t req_o,
  output logic [7:0]                  arr_o
);
  // The request stands for the whole cycle, as a real core presents it.
  assign req_o = {issue_i, kind_i, eeprom_i, target_i, pc_i};
  // Data follows the address; when idle it is inverted so stale bytes never look valid.
  assign arr_o = issue_i ? (target_i[7:0] ^ target_i[15:8] ^ 8'h5a) : ~target_i[7:0];
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the flash protection checker, with a behavioural model.
// Assumes a one-cycle answer on both the Wishbone slave and the access port.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                          clk_i, rst_i, cyc_i, stb_i, we_i, prog_mode_i, ack_o;
  logic [31:0]                   adr_i, dat_i, dat_o;
  logic [3:0]                    sel_i;
  logic                          iss, eep;
  logic [2:0]                    knd;
  logic [21:0]                   tgt, pcv;
  logic [7:0]                    arr;
  flash_guard_pkg::access_req_t  req;
  flash_guard_pkg::access_resp_t resp_o;
  int                            fail_count, cmp_count, seed;
  int                            g[7];
  logic [29:0] idx[9] = '{30'h300008, 30'h300009, 30'h30000a, 30'h30000b, 30'h30000c,
                          30'h30000d, 30'h300006, 30'h300007, 30'h30000e};
  logic [7:0]  msk[7] = '{8'hff, 8'hc0, 8'hff, 8'he0, 8'hff, 8'h40, 8'h30};
  logic [7:0]  clr[7] = '{8'hff, 8'hc0, 8'hff, 8'hc0, 8'hff, 8'h40, 8'h00};

  // The clock runs at 20 MHz.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  flash_block_protection i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .prog_mode_i(prog_mode_i), .req_i(req), .arr_rdata_i(arr), .resp_o(resp_o));
  core_port_model i_core (.issue_i(iss), .kind_i(knd), .eeprom_i(eep), .target_i(tgt),
    .pc_i(pcv), .req_o(req), .arr_o(arr));

  // Counts a comparison and reports a mismatch at once.
  task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Xorshift source with a fixed start, so every run repeats.
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // One classic Wishbone cycle; the request holds until ack is seen high.
  task automatic wb(logic w, int k, logic [7:0] d, logic s, output logic [7:0] q);
    int n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx[k], 2'b00};
    dat_i <= {24'h000000, d};
    sel_i <= {3'b000, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  // Reads every index, unmapped ones included, against the model.
  task automatic reg_pass();
    logic [7:0] q;
    for (int k = 0; k < 9; k++) begin
      wb(1'b0, k, 8'h00, 1'b1, q);
      check("reg_read", q, k < 7 ? 8'(g[k]) : 8'h00);
    end
  endtask

  // Writes one byte; normal execution may only clear, and only while config is open.
  task automatic reg_wr(int k, logic [7:0] d, logic s);
    logic [7:0] q;
    wb(1'b1, k, d, s, q);
    if (k < 7 && s && (prog_mode_i || g[3][5]))
      g[k] = prog_mode_i ? d & msk[k] : g[k] & (d | ~clr[k]);
  endtask

  task automatic setmode(logic m);
    @(posedge clk_i);
    prog_mode_i <= m;
  endtask

  // Region of an address: 0-7 blocks, 8 boot, 9 config, 10 outside.
  function automatic int region(int a);
    int be;
    be = g[6][5:4] == 0 ? 'h800 : g[6][5:4] == 1 ? 'h1000 : 'h2000;
    if (a < be) return 8;
    if (a < 'h4000) return 0;
    if (a < 'h20000) return a >> 14;
    if ((a >> 8) == 'h3000) return 9;
    return 10;
  endfunction

  function automatic logic allow(int k, logic e, int t, int p);
    int r;
    r = e ? 11 : region(t);
    if (k == 0 || r == 10) return k < 5;
    if (k == 1) return e || r == 9 || region(p) == r || (r < 8 ? g[4][r] : g[5][6]);
    if (k == 2 || k == 3) return e ? g[3][7] : r < 8 ? g[2][r] : r == 8 ? g[3][6] : g[3][5];
    if (k == 4) return e ? g[1][7] : r < 8 ? g[0][r] : r == 8 ? g[1][6] : 1'b1;
    return 1'b0;
  endfunction

  // Back-to-back random requests; each answer is checked one cycle after its request.
  task automatic traffic(int n);
    int r, k, t, p;
    logic e, pv, pa, pm;
    logic [7:0] pd;
    {pv, pa, pm, pd} = 11'h000;
    for (int j = 0; j <= n + 1; j++) begin
      r = rnd();
      k = (r & 15) % 6;
      e = ((r >> 4) & 7) == 0;
      t = (r >> 8) & 'h1ffff;
      if (((r >> 25) & 7) == 0) t = 'h300000 | (t & 'hff);
      if (((r >> 25) & 7) == 1) t = 'h100000;
      if (((r >> 25) & 7) == 2) t = t & 'h3fff;
      p = r[28] ? t ^ (r & 'h3ff) : rnd() & 'h1ffff;
      @(posedge clk_i);
      iss <= j < n;
      knd <= 3'(k);
      eep <= e;
      tgt <= 22'(t);
      pcv <= 22'(p);
      @(negedge clk_i);
      check("valid", 8'(resp_o.valid), 8'(pv));
      check("allow", 8'(resp_o.allow), 8'(pv & pa));
      check("commit", 8'(resp_o.commit), 8'(pm));
      check("rdata", resp_o.rdata, pd);
      pv = j < n;
      pa = allow(k, e, t, p);
      pm = pv & pa & (k == 2 || k == 3);
      pd = (pv & pa & !pm) ? (t[7:0] ^ t[15:8] ^ 8'h5a) : 8'h00;
    end
  endtask

  // Main sequence: reset, reset values, then each boot size with random guard bytes.
  initial begin
    seed = 4513;
    fail_count = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, prog_mode_i, iss, eep} = 6'h00;
    adr_i = 32'h00000000;
    dat_i = 32'h00000000;
    sel_i = 4'h0;
    knd = 3'h0;
    tgt = 22'h000000;
    pcv = 22'h000000;
    g = '{'hff, 'hc0, 'hff, 'he0, 'hff, 'h40, 'h00};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    reg_pass();
    traffic(20);
    for (int b = 0; b < 4; b++) begin
      setmode(1'b1);
      // Odd passes act as a smaller part: the programmer keeps the top two block bits at one.
      for (int k = 0; k < 7; k++)
        reg_wr(k, k == 6 ? 8'(b << 4) : 8'(rnd() | ((b & ~k & 1) * 'hc0)), 1'b1);
      setmode(1'b0);
      reg_pass();
      traffic(60);
      for (int k = 0; k < 9; k++) reg_wr(k, 8'(rnd()), rnd() % 4 != 0);
      reg_pass();
      traffic(30);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
